// file: common/sapc_map.svh
// constants for the converter control block: widths and timing counts
// assumes a 200 MHz core clock; included by bare name
`ifndef SAPC_MAP_SVH
`define SAPC_MAP_SVH

// ****************************************
// clock and timing
// ****************************************
`define SAPC_CLK_PERIOD_PS 5000
`define SAPC_CONV_TYP_PS 2450000
`define SAPC_CONV_MAX_PS 2800000
`define SAPC_NAP_WAKE_PS 200000
// conversion length: typical time rounded down to whole cycles
`define SAPC_CONV_CYCLES (`SAPC_CONV_TYP_PS / `SAPC_CLK_PERIOD_PS)
// nap wake: longest time, rounded down
`define SAPC_NAP_CYCLES (`SAPC_NAP_WAKE_PS / `SAPC_CLK_PERIOD_PS)

// ****************************************
// result layout and reset values
// ****************************************
`define SAPC_RESULT_WIDTH 16
`define SAPC_RESULT_MSB 15
`define SAPC_RESULT_RESET 16'h0000

`endif

// file: common/sapc_pkg.sv
// types for the converter control block
// assumes nothing beyond the map header
package sapc_pkg;

  // ****************************************
  // converter sequencing states
  // ****************************************
  typedef enum logic [1:0] {
    SAPC_IDLE,
    SAPC_CONVERT,
    SAPC_NAP,
    SAPC_SLEEP
  } sapc_state_e;

endpackage

// file: verilog/sapc_control.sv
// control and parallel output logic of a 16-bit successive approximation converter
// assumes host strobes arrive asynchronously on pins and the comparator decision is a pin input
//
// Summary of operation
// - sixteen-line three-state result bus, top line is the most significant bit
// - busy low for whole conversion, rises when result is valid
// - drive result bus only while read and chip select are both low
// - falling conversion start with chip select low begins a conversion
// - clear the bit search register when a conversion begins
// - ignore further start requests until the running conversion completes
// - resolve bits one per step, most significant first
// - move full search result into the output latches at conversion end
// - every result is a two's complement number
// - conversion timed by the internal clock, no external clock needed
// - conversion lasts typically 2.45 us, never over 2.8 us; the default counts give 16 steps of 30 cycles, 2.4 us
// - acquisition plus conversion fit within three microseconds per sample
// - power down low gives shutdown: nap if chip select low, else sleep
// - nap keeps logic powered; ready again within 200 ns of release
// - read and chip select held low keep the bus driven continuously
// - chip select alone low keeps bus floating until read pulses
// - slow memory: joint strobe starts and shows previous, new at busy rise
// - ROM style: joint strobe reads previous result and starts next
`include "sapc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sapc_control
  import sapc_pkg::*;
#(
  parameter int RESULT_WIDTH = `SAPC_RESULT_WIDTH,
  parameter int CONV_CYCLES = `SAPC_CONV_CYCLES,
  parameter int NAP_CYCLES = `SAPC_NAP_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic conversionStartN,
  input wire logic powerDownN,
  input wire logic compareHigh,
  output logic busyN,
  output logic [RESULT_WIDTH-1:0] resultBusOut,
  output logic resultBusOe,
  output logic [RESULT_WIDTH-1:0] trialBits,
  output logic napActive,
  output logic sleepActive,
  output logic resultValid,
  input wire logic resultReady
);

  localparam int STEP_CYCLES = CONV_CYCLES / RESULT_WIDTH;
  localparam int STEP_W = $clog2(STEP_CYCLES + 1);
  localparam int BIT_W = $clog2(RESULT_WIDTH);
  localparam int NAP_W = $clog2(NAP_CYCLES + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] csSync_ff;
  logic [2:0] rdSync_ff;
  logic [2:0] cvSync_ff;
  logic [2:0] pdSync_ff;
  logic [2:0] cmpSync_ff;
  logic csN_ff;
  logic rdN_ff;
  logic cvN_ff;
  logic pdN_ff;
  logic cmp_ff;

  // three stages per pin; second and third must agree before a change counts
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      csSync_ff <= 3'h7;
      rdSync_ff <= 3'h7;
      cvSync_ff <= 3'h7;
      pdSync_ff <= 3'h7;
      cmpSync_ff <= 3'h0;
    end else begin
      csSync_ff <= {csSync_ff[1:0], chipSelectN};
      rdSync_ff <= {rdSync_ff[1:0], readStrobeN};
      cvSync_ff <= {cvSync_ff[1:0], conversionStartN};
      pdSync_ff <= {pdSync_ff[1:0], powerDownN};
      cmpSync_ff <= {cmpSync_ff[1:0], compareHigh};
    end
  end

  // filtered levels
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      csN_ff <= 1'h1;
      rdN_ff <= 1'h1;
      cvN_ff <= 1'h1;
      pdN_ff <= 1'h1;
      cmp_ff <= 1'h0;
    end else begin
      if (csSync_ff[1] == csSync_ff[2]) csN_ff <= csSync_ff[2];
      if (rdSync_ff[1] == rdSync_ff[2]) rdN_ff <= rdSync_ff[2];
      if (cvSync_ff[1] == cvSync_ff[2]) cvN_ff <= cvSync_ff[2];
      if (pdSync_ff[1] == pdSync_ff[2]) pdN_ff <= pdSync_ff[2];
      if (cmpSync_ff[1] == cmpSync_ff[2]) cmp_ff <= cmpSync_ff[2];
    end
  end

  // ****************************************
  // start detection
  // ****************************************
  logic cvPrev_ff;
  logic startFall;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cvPrev_ff <= 1'h1;
    end else begin
      cvPrev_ff <= cvN_ff;
    end
  end

  // falling start edge while selected
  assign startFall = cvPrev_ff & ~cvN_ff & ~csN_ff;

  // ****************************************
  // sequencer
  // ****************************************
  sapc_state_e state_ff;
  logic [STEP_W-1:0] stepCnt_ff;
  logic [BIT_W-1:0] bitIdx_ff;
  logic [NAP_W-1:0] wakeCnt_ff;
  logic [RESULT_WIDTH-1:0] search_ff;
  logic stepDone;
  logic lastBit;
  logic convDone;
  logic awake;

  assign stepDone = (stepCnt_ff == STEP_W'(STEP_CYCLES - 1));
  assign lastBit = (bitIdx_ff == '0);
  assign convDone = (state_ff == SAPC_CONVERT) & stepDone & lastBit;
  assign awake = (wakeCnt_ff == '0);

  // state: shutdown has priority, start taken only in idle once awake
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= SAPC_IDLE;
    end else begin
      case (state_ff)
        SAPC_IDLE: begin
          if (!pdN_ff) begin
            state_ff <= csN_ff ? SAPC_SLEEP : SAPC_NAP;
          end else if (startFall && awake) begin
            state_ff <= SAPC_CONVERT;
          end
        end
        SAPC_CONVERT: begin
          // further starts are not looked at here
          if (convDone) state_ff <= SAPC_IDLE;
        end
        SAPC_NAP, SAPC_SLEEP: begin
          if (pdN_ff) state_ff <= SAPC_IDLE;
        end
        default: state_ff <= SAPC_IDLE;
      endcase
    end
  end

  // wake delay after nap release
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wakeCnt_ff <= '0;
    end else if (state_ff == SAPC_NAP || state_ff == SAPC_SLEEP) begin
      wakeCnt_ff <= NAP_W'(NAP_CYCLES);
    end else if (!awake) begin
      wakeCnt_ff <= wakeCnt_ff - 1'b1;
    end
  end

  // step timer from the internal clock
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stepCnt_ff <= '0;
    end else if (state_ff != SAPC_CONVERT || stepDone) begin
      stepCnt_ff <= '0;
    end else begin
      stepCnt_ff <= stepCnt_ff + 1'b1;
    end
  end

  // bit index walks from msb down
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bitIdx_ff <= BIT_W'(RESULT_WIDTH - 1);
    end else if (state_ff != SAPC_CONVERT) begin
      bitIdx_ff <= BIT_W'(RESULT_WIDTH - 1);
    end else if (stepDone && !lastBit) begin
      bitIdx_ff <= bitIdx_ff - 1'b1;
    end
  end

  // search register: cleared at start, trial bit kept or dropped each step
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      search_ff <= '0;
    end else if (state_ff == SAPC_IDLE && startFall && awake && pdN_ff) begin
      search_ff <= '0;
    end else if (state_ff == SAPC_CONVERT && stepDone) begin
      search_ff[bitIdx_ff] <= cmp_ff;
    end
  end

  // trial word to the dac: decided bits plus the bit under test
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trialBits <= '0;
    end else if (state_ff == SAPC_CONVERT) begin
      trialBits <= search_ff | (RESULT_WIDTH'(1) << bitIdx_ff);
    end else begin
      trialBits <= search_ff;
    end
  end

  // ****************************************
  // output latches and busy
  // ****************************************
  logic [RESULT_WIDTH-1:0] latch_ff;
  logic [RESULT_WIDTH-1:0] finalWord;
  logic convDoneDly_ff;

  // two's complement word, sign in the top bit
  always_comb begin
    finalWord = search_ff;
    finalWord[0] = cmp_ff;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      latch_ff <= `SAPC_RESULT_RESET;
    end else if (convDone) begin
      latch_ff <= finalWord;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      convDoneDly_ff <= 1'h0;
    end else begin
      convDoneDly_ff <= convDone;
    end
  end

  // busy low while converting; rises on the same edge that the latches load
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busyN <= 1'h1;
    end else if (state_ff == SAPC_CONVERT && !convDone) begin
      busyN <= 1'h0;
    end else if (state_ff == SAPC_IDLE && startFall && awake && pdN_ff) begin
      busyN <= 1'h0;
    end else begin
      busyN <= 1'h1;
    end
  end

  // bus drive: enable follows read and select, result word follows the latches
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      resultBusOut <= '0;
      resultBusOe <= 1'h0;
    end else begin
      // new word shows on the same edge that busy rises, not one cycle later
      resultBusOut <= convDone ? finalWord : latch_ff;
      resultBusOe <= ~rdN_ff & ~csN_ff;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      napActive <= 1'h0;
      sleepActive <= 1'h0;
    end else begin
      napActive <= (state_ff == SAPC_NAP);
      sleepActive <= (state_ff == SAPC_SLEEP);
    end
  end

  // ****************************************
  // two-entry result buffer
  // ****************************************
  logic [RESULT_WIDTH-1:0] buf_ff [2];
  logic [1:0] bufCnt_ff;
  logic bufRd_ff;
  logic bufWr_ff;
  logic push;
  logic pop;

  // a full buffer keeps the oldest words: the newest word is refused and dropped
  assign push = convDoneDly_ff && (bufCnt_ff != 2'h2);
  assign pop = resultValid && resultReady;

  always_ff @(posedge core_clk) begin
    if (push) buf_ff[bufWr_ff] <= latch_ff;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bufCnt_ff <= 2'h0;
      bufRd_ff <= 1'h0;
      bufWr_ff <= 1'h0;
    end else begin
      if (push) bufWr_ff <= ~bufWr_ff;
      if (pop) bufRd_ff <= ~bufRd_ff;
      bufCnt_ff <= bufCnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // combinational read of the buffer head; head drives no output
  logic [RESULT_WIDTH-1:0] head;
  assign head = buf_ff[bufRd_ff];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      resultValid <= 1'h0;
    end else begin
      resultValid <= (bufCnt_ff + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end

endmodule

`default_nettype wire

// file: verification/sapc_control_checker.sv
// checker for the converter control block, watching the top ports only
// assumes the design is named sapc_control and bound from below
`timescale 1ns/1ps
`default_nettype none

module sapc_control_checker #(
  parameter int RESULT_WIDTH = 16,
  parameter int CONV_CYCLES = 490,
  parameter int NAP_CYCLES = 40
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic conversionStartN,
  input wire logic powerDownN,
  input wire logic busyN,
  input wire logic [RESULT_WIDTH-1:0] resultBusOut,
  input wire logic resultBusOe,
  input wire logic napActive,
  input wire logic sleepActive,
  input wire logic resultValid,
  input wire logic resultReady
);
  // ****************************************
  // helpers and properties
  // ****************************************
  localparam int BUSY_MAX = CONV_CYCLES + 4;
  int lowCnt_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // counts cycles of the running conversion
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lowCnt_ff <= 0;
    end else if (busyN) begin
      lowCnt_ff <= 0;
    end else begin
      lowCnt_ff <= lowCnt_ff + 1;
    end
  end

  a_busy_bounded: assert property ($fell(busyN) |-> ##[1:BUSY_MAX] busyN)
    else $error("conversion overran its bound");
  a_busy_full_len: assert property ($rose(busyN) |-> lowCnt_ff >= CONV_CYCLES)
    else $error("conversion ended early");
  a_start_needs_cs: assert property (chipSelectN [*8] ##0 busyN |=> busyN)
    else $error("conversion began while deselected");
  a_oe_off_cs: assert property (chipSelectN [*6] |-> !resultBusOe)
    else $error("bus driven while deselected");
  a_oe_off_rd: assert property (readStrobeN [*6] |-> !resultBusOe)
    else $error("bus driven without read");
  a_oe_on_both: assert property ((!chipSelectN && !readStrobeN) [*6] |-> resultBusOe)
    else $error("bus not driven while read and select low");
  a_nap_select: assert property ((!powerDownN && !chipSelectN) [*8] |-> napActive && !sleepActive)
    else $error("nap not selected");
  a_sleep_select: assert property ((!powerDownN && chipSelectN) [*8] |-> sleepActive && !napActive)
    else $error("sleep not selected");
  a_result_held: assert property ($fell(busyN) |=> $stable(resultBusOut) [*8])
    else $error("result changed early in conversion");
  a_valid_after: assert property ($rose(busyN) |-> ##[0:4] resultValid)
    else $error("no result word after conversion");

  // main scenarios reached
  c_conv_done: cover property ($rose(busyN));
  c_nap: cover property (napActive);
  c_sleep: cover property (sleepActive);
  c_pop: cover property (resultValid && resultReady);
endmodule

bind sapc_control sapc_control_checker #(.RESULT_WIDTH(RESULT_WIDTH), .CONV_CYCLES(CONV_CYCLES),
  .NAP_CYCLES(NAP_CYCLES)) u_chk (.core_clk(core_clk), .reset(reset), .chipSelectN(chipSelectN),
  .readStrobeN(readStrobeN), .conversionStartN(conversionStartN), .powerDownN(powerDownN),
  .busyN(busyN), .resultBusOut(resultBusOut), .resultBusOe(resultBusOe), .napActive(napActive),
  .sleepActive(sleepActive), .resultValid(resultValid), .resultReady(resultReady));

`default_nettype wire

// file: verification/sapc_comparator_model.sv
// comparator model: answers each trial word from a target code
// assumes the lowest set bit of the trial word is the bit under trial
`timescale 1ns/1ps
`default_nettype none

module sapc_comparator_model (
  input wire logic [15:0] trialBits,
  input wire logic [15:0] target,
  output logic compareHigh
);
  // keep the trial bit when the target has it set
  always_comb begin
    compareHigh = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (trialBits[i]) begin
        compareHigh = target[i];
      end
    end
  end
endmodule

`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the converter control block
// assumes a shortened conversion count and the comparator model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ****************************************
  // stimulus, model and helpers
  // ****************************************
  // each step must outlast the comparator pin's synchroniser (about 5 cycles): 10 cycles per bit
  localparam int CONV = 160;
  localparam int NAP = 40;
  logic core_clk, reset, chipSelectN, readStrobeN, conversionStartN, powerDownN, compareHigh;
  logic busyN, resultBusOe, napActive, sleepActive, resultValid, resultReady;
  logic [15:0] resultBusOut, trialBits, target;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int dur;

  sapc_control #(.CONV_CYCLES(CONV), .NAP_CYCLES(NAP)) dut (.core_clk(core_clk), .reset(reset),
    .chipSelectN(chipSelectN), .readStrobeN(readStrobeN), .conversionStartN(conversionStartN),
    .powerDownN(powerDownN), .compareHigh(compareHigh), .busyN(busyN), .resultBusOut(resultBusOut),
    .resultBusOe(resultBusOe), .trialBits(trialBits), .napActive(napActive),
    .sleepActive(sleepActive), .resultValid(resultValid), .resultReady(resultReady));
  sapc_comparator_model model (.trialBits(trialBits), .target(target), .compareHigh(compareHigh));

  // clock and cycle count
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busyN !== lvl) begin
      tick(1);
      n++;
      if (n > 400) begin
        err_total++;
        end_of_test();
      end
    end
  endtask
  // one conversion, optionally pestered by a second start; dur is start to busy rise
  task automatic convert(input logic [15:0] val, input bit again);
    int t0;
    target = val;
    t0 = cyc;
    conversionStartN = 1'b0;
    tick(10); // back high after 50 ns
    conversionStartN = 1'b1;
    wait_busy(1'b0);
    if (again) begin
      tick(4);
      conversionStartN = 1'b0;
      tick(10);
      conversionStartN = 1'b1;
    end
    wait_busy(1'b1);
    dur = cyc - t0;
    chk16({15'h0, dur >= CONV + 2 && dur <= CONV + 8}, 16'h0001);
    tick(96); // acquisition time before the next start
  endtask
  task automatic read_check(input logic [15:0] exp);
    readStrobeN = 1'b0;
    tick(6);
    chk16({15'h0, resultBusOe}, 16'h0001);
    chk16(resultBusOut, exp);
    readStrobeN = 1'b1;
    tick(6);
    chk16({15'h0, resultBusOe}, 16'h0000);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_values();
    logic [15:0] vals[4] = '{16'h8001, 16'h7FFE, 16'hFFFF, 16'h0000};
    foreach (vals[i]) begin
      convert(vals[i], i == 1);
      read_check(vals[i]);
    end
  endtask
  task automatic sc_deselected();
    chipSelectN = 1'b1;
    readStrobeN = 1'b0;
    conversionStartN = 1'b0;
    tick(10);
    conversionStartN = 1'b1;
    tick(30);
    chk16({15'h0, busyN, resultBusOe}, 16'h0002);
    readStrobeN = 1'b1;
    chipSelectN = 1'b0;
    tick(6);
  endtask
  task automatic sc_slow_memory();
    readStrobeN = 1'b0;
    conversionStartN = 1'b0;
    target = 16'h1234;
    tick(6);
    chk16(resultBusOut, 16'h0000);
    wait_busy(1'b1);
    tick(2);
    chk16(resultBusOut, 16'h1234);
    readStrobeN = 1'b1;
    conversionStartN = 1'b1;
    tick(96);
    convert(16'hA5C3, 1'b0);
    read_check(16'hA5C3);
  endtask
  task automatic sc_shutdown();
    powerDownN = 1'b0;
    tick(10);
    chk16({14'h0, napActive, sleepActive}, 16'h0002);
    powerDownN = 1'b1;
    tick(NAP + 10); // nap wake time
    convert(16'h4C01, 1'b0);
    read_check(16'h4C01);
    chipSelectN = 1'b1;
    powerDownN = 1'b0;
    tick(10);
    chk16({14'h0, napActive, sleepActive}, 16'h0001);
    powerDownN = 1'b1;
    tick(10); // reference settling scaled down
    chipSelectN = 1'b0;
    tick(NAP + 10);
  endtask
  task automatic sc_buffer();
    int pops;
    resultReady = 1'b0;
    convert(16'h0101, 1'b0);
    convert(16'h0202, 1'b0);
    convert(16'h0303, 1'b0);
    chk16({15'h0, resultValid}, 16'h0001);
    pops = 0;
    resultReady = 1'b1;
    repeat (10) begin
      @(posedge core_clk);
      if (resultValid === 1'b1) pops++;
    end
    #1;
    chk16(pops[15:0], 16'h0002);
  endtask

  // reset, then every scenario in turn
  initial begin
    reset = 1'b1;
    chipSelectN = 1'b0;
    readStrobeN = 1'b1;
    conversionStartN = 1'b1;
    powerDownN = 1'b1;
    resultReady = 1'b1;
    target = 16'h0000;
    tick(10);
    chk16({12'h0, busyN, resultBusOe, napActive, sleepActive}, 16'h0008);
    reset = 1'b0;
    tick(8);
    chk16({15'h0, resultValid}, 16'h0000);
    sc_values();
    sc_deselected();
    sc_slow_memory();
    sc_shutdown();
    sc_buffer();
    end_of_test();
  end
endmodule

`default_nettype wire
